// file: inc/drbi_map.svh
// Constants of the dual-rail bias supply serial write control block.
// Included by both rtl modules and the bench top; definitions only.
`ifndef DRBI_MAP_SVH
`define DRBI_MAP_SVH

// System clock period in ns
`define DRBI_CLK_NS 4

// Serial target address and register indices
`define DRBI_DEV_ADDR 7'h3e
`define DRBI_IDX_POS 8'h00
`define DRBI_IDX_NEG 8'h01
`define DRBI_IDX_MODE 8'h03
`define DRBI_ACK_SLOT 4'h8

// Register reset values
`define DRBI_CODE_RST 5'h0a
`define DRBI_MODE_RST 8'h03

// Protection timing
`define DRBI_OCP_WIN_US 300
`define DRBI_OCP_WIN_CYC ((`DRBI_OCP_WIN_US * 1000) / `DRBI_CLK_NS)
`define DRBI_SCP_MS 10
`define DRBI_SCP_CYC ((`DRBI_SCP_MS * 1000000) / `DRBI_CLK_NS)

// Host sequencing timing (least times, rounded up)
`define DRBI_HOLD_MS 1
`define DRBI_HOLD_CYC \
	((`DRBI_HOLD_MS * 1000000 + `DRBI_CLK_NS - 1) / `DRBI_CLK_NS)
`define DRBI_LEVEL_MS 45
`define DRBI_LEVEL_CYC \
	((`DRBI_LEVEL_MS * 1000000 + `DRBI_CLK_NS - 1) / `DRBI_CLK_NS)
`define DRBI_LOAD_MS 55
`define DRBI_LOAD_CYC \
	((`DRBI_LOAD_MS * 1000000 + `DRBI_CLK_NS - 1) / `DRBI_CLK_NS)
`define DRBI_SCL_QTR_NS 2500
`define DRBI_SCL_QTR_CYC \
	((`DRBI_SCL_QTR_NS + `DRBI_CLK_NS - 1) / `DRBI_CLK_NS)

// Host APB register offsets and fields
`define DRBI_REG_CTRL 8'h00
`define DRBI_REG_XFER 8'h04
`define DRBI_REG_STAT 8'h08
`define DRBI_CTRL_EN1 0
`define DRBI_CTRL_EN2 1
`define DRBI_STAT_BUSY 0
`define DRBI_STAT_NACK 1
`define DRBI_STAT_LEVEL 2
`define DRBI_STAT_LOAD 3

`endif

// file: inc/drbi_pkg.sv
// Types shared by both ends of the bias supply serial link.
// Assumes the constants of drbi_map.svh for all figures.
package drbi_pkg;

	// Target receive states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INDEX = 3'b010,
		ST_DATA = 3'b011,
		ST_IGNORE = 3'b100
	} drbi_rx_e;

	// Positive rail current limit mode
	typedef enum logic [1:0] {
		LIM_OFF = 2'b00,
		LIM_STRICT = 2'b01,
		LIM_FREE = 2'b10,
		LIM_WEAK = 2'b11
	} drbi_limit_e;

	// Controller serial engine states
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BIT = 2'b10,
		H_STOP = 2'b11
	} drbi_tx_e;

endpackage : drbi_pkg

// file: inc/drbi_if.sv
// Link between the bias supply target and its controller.
// The data line is open drain with a pull-up; the clock is driven by the
// controller alone, push-pull.
`timescale 1ns/1ps
`default_nettype none

interface drbi_if;
	logic scl;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda;
	logic first_enable_pin;
	logic second_enable_pin;

	// Wired-AND with pull-up: any enabled low driver wins
	assign sda = !((sda_host_oe && !sda_host_o) ||
		(sda_dev_oe && !sda_dev_o));

	modport dev (
		input scl, sda, first_enable_pin, second_enable_pin,
		output sda_dev_o, sda_dev_oe
	);
	modport host (
		input sda,
		output scl, sda_host_o, sda_host_oe,
		first_enable_pin, second_enable_pin
	);
endinterface : drbi_if

`default_nettype wire

// file: rtl/drbi_controller.sv
// Controller end: APB registers, enable pin sequencing and a write-only
// serial master. Assumes mclk at 250 MHz and a target on drbi_if.
`timescale 1ns/1ps
`default_nettype none
`include "drbi_map.svh"

module drbi_controller
	import drbi_pkg::*;
#(
	parameter int unsigned HOLD_CYC = `DRBI_HOLD_CYC,
	parameter int unsigned LEVEL_CYC = `DRBI_LEVEL_CYC,
	parameter int unsigned LOAD_CYC = `DRBI_LOAD_CYC,
	parameter int unsigned QTR_CYC = `DRBI_SCL_QTR_CYC
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the target
	drbi_if.host link
);
	localparam int HW = $clog2(HOLD_CYC + 1);
	localparam int TW = $clog2(LOAD_CYC + 1);
	localparam int QW = $clog2(QTR_CYC + 1);

	logic [1:0] en_req, en_pin, sda_sync;
	logic [HW-1:0] hold_cnt [2];
	logic [TW-1:0] up_cnt;
	logic [7:0] x_index, x_data;
	logic [26:0] tx;
	logic nack, go, busy;
	logic [QW-1:0] q_cnt;
	logic [1:0] phase;
	logic [3:0] bit_no;
	logic [1:0] byte_no;
	logic scl, sda_oe;
	drbi_tx_e st;

	wire wr_acc = psel && penable && pwrite;
	wire tick = (q_cnt == QW'(QTR_CYC - 1));
	wire level_ok = (up_cnt >= TW'(LEVEL_CYC));
	wire load_ok = (up_cnt >= TW'(LOAD_CYC));
	assign busy = (st != H_IDLE) || go;

	// Zero-wait slave; read data and error are set up in the setup cycle
	assign pready = 1'b1;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			unique case (paddr)
				`DRBI_REG_CTRL: prdata <= {30'h0, en_req};
				`DRBI_REG_XFER: prdata <= {16'h0, x_index, x_data};
				`DRBI_REG_STAT: prdata <= {28'h0, load_ok, level_ok, nack, busy};
				default: pslverr <= 1'b1;
			endcase
		end
	end

	// Software registers; a transfer write while busy is dropped
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_req <= 2'b00;
			x_index <= 8'h00;
			x_data <= 8'h00;
			go <= 1'b0;
		end else begin
			if (st == H_START)
				go <= 1'b0;
			if (wr_acc && paddr == `DRBI_REG_CTRL)
				en_req <= pwdata[1:0];
			if (wr_acc && paddr == `DRBI_REG_XFER && !busy) begin
				x_index <= pwdata[15:8];
				x_data <= pwdata[7:0];
				go <= 1'b1;
			end
		end
	end

	// Enable pins change only after each level has stood its least time
	for (genvar g = 0; g < 2; g++) begin : g_en
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				en_pin[g] <= 1'b0;
				hold_cnt[g] <= HW'(HOLD_CYC);
			end else if (en_req[g] != en_pin[g] &&
				hold_cnt[g] == HW'(HOLD_CYC)) begin
				en_pin[g] <= en_req[g]; // RL17 RL12
				hold_cnt[g] <= '0;
			end else if (hold_cnt[g] != HW'(HOLD_CYC)) begin
				hold_cnt[g] <= hold_cnt[g] + HW'(1);
			end
		end
	end
	assign link.first_enable_pin = en_pin[0];
	assign link.second_enable_pin = en_pin[1];

	// Time since the first enable rose; sets the level and load status bits
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			up_cnt <= '0;
		else if (!en_pin[0])
			up_cnt <= '0;
		else if (!load_ok)
			up_cnt <= up_cnt + TW'(1); // RL14 RL16
	end

	// Data line is sampled through two flops before use
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			sda_sync <= 2'b11;
		else
			sda_sync <= {sda_sync[0], link.sda};
	end

	// Quarter bit timer; runs only while a frame is in progress
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			q_cnt <= '0;
		else if (st == H_IDLE || tick)
			q_cnt <= '0;
		else
			q_cnt <= q_cnt + QW'(1);
	end

	// Serial engine: start, address, index, data, each acknowledged, stop
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= H_IDLE;
			phase <= 2'b00;
			bit_no <= 4'h0;
			byte_no <= 2'b00;
			tx <= '1;
			scl <= 1'b1;
			sda_oe <= 1'b0;
			nack <= 1'b0;
		end else begin
			if (wr_acc && paddr == `DRBI_REG_STAT && pwdata[`DRBI_STAT_NACK])
				nack <= 1'b0;
			unique case (st)
				H_IDLE: begin // RL1
					scl <= 1'b1;
					sda_oe <= 1'b0;
					if (go) begin
						st <= H_START;
						phase <= 2'b00;
						sda_oe <= 1'b1; // RL2
						tx <= {`DRBI_DEV_ADDR, 1'b0, 1'b1, x_index, 1'b1,
							x_data, 1'b1}; // RL8 RL20
					end
				end
				H_START: if (tick) begin
					scl <= 1'b0;
					st <= H_BIT;
					phase <= 2'b00;
					bit_no <= 4'h0;
					byte_no <= 2'b00;
				end
				H_BIT: if (tick) begin
					phase <= phase + 2'b01;
					unique case (phase)
						2'b00: begin
							sda_oe <= !tx[26]; // RL4 RL6
							tx <= {tx[25:0], 1'b1};
						end
						2'b01: scl <= 1'b1;
						2'b10: begin
							scl <= 1'b0;
							if (bit_no == `DRBI_ACK_SLOT && sda_sync[1])
								nack <= 1'b1;
						end
						2'b11: begin
							if (bit_no != `DRBI_ACK_SLOT) begin
								bit_no <= bit_no + 4'h1; // RL5
							end else if (byte_no == 2'b10 || nack) begin
								st <= H_STOP;
								phase <= 2'b00;
							end else begin
								bit_no <= 4'h0;
								byte_no <= byte_no + 2'b01;
							end
						end
					endcase
				end
				H_STOP: if (tick) begin
					phase <= phase + 2'b01;
					unique case (phase)
						2'b00: sda_oe <= 1'b1;
						2'b01: scl <= 1'b1;
						2'b10: sda_oe <= 1'b0; // RL3
						2'b11: st <= H_IDLE;
					endcase
				end
			endcase
		end
	end

	assign link.scl = scl;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = sda_oe;

endmodule : drbi_controller

`default_nettype wire

// file: rtl/drbi_target.sv
// Target end: write-only serial register port, enable handling and
// current and short-circuit guard timing for a dual-rail bias supply.
// Assumes a controller on drbi_if and analog comparators on rail_*.
`timescale 1ns/1ps
`default_nettype none
`include "drbi_map.svh"

// Notes on behaviour
// RL1: Idle bus leaves clock and data high
// RL2: Data falling under high clock starts access
// RL3: Data rising under high clock ends access
// RL4: Sender keeps data steady while clock high
// RL5: Bytes of eight bits, any count
// RL6: Receiver pulls data low after eighth fall
// RL7: Receiver releases data at ninth fall
// RL8: First byte is address then direction bit
// RL9: Only write direction is accepted
// RL10: Index byte, then data with auto increment
// RL11: Each rail governed by own pin, codes
// RL12: Enables active high, low means off
// RL13: Power-on reset clears all, fault latch too
// RL14: High codes only after 45 ms enable
// RL15: Default code written before disabling
// RL16: Panel load after 55 ms enable
// RL17: Each enable level held one ms minimum
// RL18: Strict limit for 300 us from ramp
// RL19: Late ramp drops to weak limit
// RL20: Own address fixed, direction must be low
// RL21: Shutdown writes code ten before enables low
// RL22: Below sixty percent for 10 ms latches off
// RL23: Foreign address gets no acknowledge
module drbi_target
	import drbi_pkg::*;
#(
	parameter int unsigned OCP_WIN_CYC = `DRBI_OCP_WIN_CYC,
	parameter int unsigned SCP_CYC = `DRBI_SCP_CYC
)(
	// Clock and power-on reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial link and enable pins
	drbi_if.dev link,
	// Rail comparators, asynchronous; bit 0 positive, bit 1 negative
	input wire logic [1:0] rail_reached,
	input wire logic [1:0] rail_below60,
	// Rail control
	output logic positive_output,
	output logic negative_output,
	output logic [4:0] positive_code,
	output logic [4:0] negative_code,
	output logic [7:0] mode_code,
	output drbi_limit_e overcurrent_guard,
	output logic short_circuit_guard,
	// Write notification
	output logic wr_stb,
	output logic [7:0] wr_index,
	output logic [7:0] wr_data
);
	localparam int OW = $clog2(OCP_WIN_CYC + 1);
	localparam int SW = $clog2(SCP_CYC + 1);

	logic [7:0] sync1, sync2;
	logic scl_d, sda_d;
	drbi_rx_e st;
	logic [3:0] bit_cnt;
	logic [7:0] shreg, index;
	logic ack_on;
	logic en1_d;
	logic [OW-1:0] ocp_cnt;
	logic [1:0] trip;
	logic [SW-1:0] scp_cnt [2];

	// Synchronised pin and comparator levels (second stage only)
	wire scl_q = sync2[0];
	wire sda_q = sync2[1];
	wire [1:0] en_q = sync2[3:2];
	wire [1:0] reached_q = sync2[5:4];
	wire [1:0] low_q = sync2[7:6];

	// Line events; data moves only while clock low except at frame ends
	wire start_ev = scl_q && scl_d && sda_d && !sda_q; // RL2
	wire stop_ev = scl_q && scl_d && !sda_d && sda_q; // RL3
	wire scl_rise = scl_q && !scl_d;
	wire scl_fall = !scl_q && scl_d;
	wire byte_end = scl_fall && bit_cnt == `DRBI_ACK_SLOT && !ack_on;
	wire data_wr = byte_end && st == ST_DATA && !start_ev && !stop_ev;
	wire fault = |trip;

	// Two-flop synchronisers for every outside level
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync1 <= 8'h03; // RL1
			sync2 <= 8'h03;
		end else begin
			sync1 <= {rail_below60, rail_reached, link.second_enable_pin,
				link.first_enable_pin, link.sda, link.scl};
			sync2 <= sync1;
		end
	end

	// Previous synchronised line levels for edge finding
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			en1_d <= 1'b0;
		end else begin
			scl_d <= scl_q;
			sda_d <= sda_q;
			en1_d <= en_q[0];
		end
	end

	// Receive state machine; bits are taken at clock rise, when stable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin // RL13
			st <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			index <= 8'h00;
			ack_on <= 1'b0;
		end else if (stop_ev) begin
			st <= ST_IDLE; // RL3
			ack_on <= 1'b0;
		end else if (start_ev) begin
			st <= ST_ADDR; // RL2
			bit_cnt <= 4'h0;
			ack_on <= 1'b0;
		end else begin
			unique case (st)
				ST_IDLE, ST_IGNORE: ack_on <= 1'b0; // RL23
				ST_ADDR, ST_INDEX, ST_DATA: begin
					if (scl_rise && bit_cnt != `DRBI_ACK_SLOT) begin
						shreg <= {shreg[6:0], sda_q}; // RL4 RL8
						bit_cnt <= bit_cnt + 4'h1; // RL5
					end else if (scl_fall && ack_on) begin
						ack_on <= 1'b0; // RL7
						bit_cnt <= 4'h0;
					end else if (byte_end) begin
						unique case (st)
							ST_ADDR: begin
								if (shreg == {`DRBI_DEV_ADDR, 1'b0}) begin
									ack_on <= 1'b1; // RL6 RL9 RL20
									st <= ST_INDEX;
								end else begin
									st <= ST_IGNORE; // RL23 RL9
								end
							end
							ST_INDEX: begin
								index <= shreg; // RL10
								ack_on <= 1'b1; // RL6
								st <= ST_DATA;
							end
							default: begin
								index <= index + 8'h01; // RL10
								ack_on <= 1'b1; // RL6
							end
						endcase
					end
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// Acknowledge is an open-drain low, driven only while ack_on
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = ack_on; // RL6 RL7

	// Level registers; unmapped indices are acknowledged but not stored
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			positive_code <= `DRBI_CODE_RST; // RL13
			negative_code <= `DRBI_CODE_RST;
			mode_code <= `DRBI_MODE_RST;
		end else if (data_wr) begin
			unique case (index)
				`DRBI_IDX_POS: positive_code <= shreg[4:0]; // RL10 RL11
				`DRBI_IDX_NEG: negative_code <= shreg[4:0]; // RL11
				`DRBI_IDX_MODE: mode_code <= shreg;
				default: ;
			endcase
		end
	end

	// One-cycle write notification with the stored index and byte
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_stb <= 1'b0;
			wr_index <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= data_wr;
			if (data_wr) begin
				wr_index <= index;
				wr_data <= shreg;
			end
		end
	end

	// Each rail follows its own pin; a latched short holds both off
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			positive_output <= 1'b0;
			negative_output <= 1'b0;
		end else begin
			positive_output <= en_q[0] && !fault; // RL11 RL12
			negative_output <= en_q[1] && !fault; // RL11 RL12
		end
	end

	// Positive rail current limit: strict window from ramp, then free or
	// weak until the rail arrives
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			overcurrent_guard <= LIM_OFF;
			ocp_cnt <= '0;
		end else if (!en_q[0] || fault) begin
			overcurrent_guard <= LIM_OFF; // RL12
			ocp_cnt <= '0;
		end else if (!en1_d) begin
			overcurrent_guard <= LIM_STRICT; // RL18
			ocp_cnt <= '0;
		end else begin
			unique case (overcurrent_guard)
				LIM_STRICT: begin
					ocp_cnt <= ocp_cnt + OW'(1);
					if (ocp_cnt == OW'(OCP_WIN_CYC - 1))
						overcurrent_guard <= reached_q[0] ?
							LIM_FREE : LIM_WEAK; // RL18 RL19
				end
				LIM_WEAK: if (reached_q[0])
					overcurrent_guard <= LIM_FREE; // RL19
				LIM_FREE, LIM_OFF: ;
			endcase
		end
	end

	// Short-circuit timers per rail; only power-on reset clears the latch
	for (genvar g = 0; g < 2; g++) begin : g_scp
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				scp_cnt[g] <= '0; // RL13
				trip[g] <= 1'b0;
			end else if (!en_q[g] || !low_q[g]) begin
				scp_cnt[g] <= '0; // RL22
			end else if (scp_cnt[g] == SW'(SCP_CYC - 1)) begin
				trip[g] <= 1'b1; // RL22
			end else begin
				scp_cnt[g] <= scp_cnt[g] + SW'(1);
			end
		end
	end
	assign short_circuit_guard = fault;

endmodule : drbi_target

`default_nettype wire

// file: tb/drbi_chk.sv
// Checker for the link lines and enable pins between the two ends.
// Assumes one mclk domain and a link quarter period of at least 4 mclk.
`timescale 1ns/1ps
`default_nettype none

module drbi_chk #(
	parameter int unsigned HOLD_CYC = 10,
	parameter int unsigned QTR_CYC = 4
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Link lines and pins
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic first_enable_pin,
	input wire logic second_enable_pin
);
	localparam int START_MAX = QTR_CYC + 2;
	logic [3:0] bitpos;
	logic [4:0] rises;
	logic [3:0] lowcnt;
	logic [7:0] hold1;
	logic [7:0] hold2;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence start_seq;
		$fell(sda) && scl;
	endsequence
	sequence stop_seq;
		$rose(sda) && scl;
	endsequence

	// Bit slot in the byte; f marks the clock fall that closes a start
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			bitpos <= 4'hf;
		else if ($fell(sda) && scl)
			bitpos <= 4'hf;
		else if ($fell(scl))
			bitpos <= (bitpos >= 4'h8) ? 4'h0 : bitpos + 4'h1;
	end

	// Clock rises since the last start, the stop's own rise included
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rises <= 5'h00;
		else if ($fell(sda) && scl)
			rises <= 5'h00;
		else if ($rose(scl))
			rises <= rises + 5'h01;
	end

	// Cycles since the clock went low, saturating
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			lowcnt <= 4'h0;
		else
			lowcnt <= scl ? 4'h0 : lowcnt + {3'h0, ~&lowcnt};
	end

	// Cycles each enable has kept its level; saturates, so long holds pass.
	// Reset starts them full: the pins sat low through reset already.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold1 <= 8'hff;
			hold2 <= 8'hff;
		end else begin
			hold1 <= $changed(first_enable_pin) ? 8'h01 : hold1 + {7'h0, ~&hold1};
			hold2 <= $changed(second_enable_pin) ? 8'h01 : hold2 + {7'h0, ~&hold2};
		end
	end

	idle_after_stop_a: assert property (stop_seq |=> (scl && sda) [*8])
		else $error("link not idle after stop");
	start_form_a: assert property (start_seq |=>
		(sda_host_oe && !sda) throughout (##[0:START_MAX] !scl))
		else $error("start not followed by clock low");
	data_steady_a: assert property (($rose(scl) && rises < 5'h1b) |=>
		$stable(sda) [*6])
		else $error("data moved while clock high");
	bit_count_a: assert property (stop_seq |->
		(rises == 5'h1c || rises == 5'h0a))
		else $error("frame not whole bytes");
	ack_slot_a: assert property ($rose(sda_dev_oe) |-> bitpos == 4'h8)
		else $error("acknowledge outside ninth bit");
	ack_time_a: assert property ($rose(sda_dev_oe) |->
		(!scl && lowcnt >= 4'h1 && lowcnt <= 4'h6))
		else $error("acknowledge late after eighth fall");
	ack_hold_a: assert property ((bitpos == 4'h8 && $rose(scl) && sda_dev_oe)
		|=> sda_dev_oe [*6])
		else $error("acknowledge dropped in ninth clock");
	ack_release_a: assert property ($fell(sda_dev_oe) |->
		(bitpos == 4'h0 && !scl && lowcnt <= 4'h6))
		else $error("acknowledge not released at ninth fall");
	hold_one_a: assert property ($changed(first_enable_pin) |-> hold1 >= HOLD_CYC)
		else $error("first enable changed too soon");
	hold_two_a: assert property ($changed(second_enable_pin) |-> hold2 >= HOLD_CYC)
		else $error("second enable changed too soon");
endmodule : drbi_chk

`default_nettype wire

// file: tb/tb_top.sv
// Bench: controller and target joined, plus a hand-driven second target.
// Assumes shortened counts; guard and link timings derive from the locals.
`timescale 1ns/1ps
`default_nettype none
`include "drbi_map.svh"

module tb_top
	import drbi_pkg::*;
;
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] data;
		logic [4:0] pos;
		logic [4:0] neg;
		logic [7:0] mode;
	} drbi_row_s;
	localparam int unsigned QTR = 4;
	localparam int unsigned OCP_WIN = 20;
	localparam int unsigned SHORT_CIRCUIT_GUARD = 50;
	localparam logic [7:0] WR_ADDR = {`DRBI_DEV_ADDR, 1'b0};
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, mode, wr_index, wr_data;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] rail_reached, rail_below60;
	logic pos_on, neg_on, short_trip, wr_stb;
	logic [4:0] pos_code, neg_code, t2_pos, t2_neg;
	logic [3:0] nacks;
	logic [27:0] wire_bits;
	drbi_limit_e guard;
	drbi_row_s rows [6];
	int miscompares, check_count, stb_count;
	drbi_if link_if ();
	drbi_if bad_if ();

	drbi_controller #(.HOLD_CYC(10), .LEVEL_CYC(40), .LOAD_CYC(60),
		.QTR_CYC(QTR)) drbi_controller_inst (.mclk(mclk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_if.host));
	drbi_target #(.OCP_WIN_CYC(OCP_WIN), .SCP_CYC(SHORT_CIRCUIT_GUARD)) drbi_target_inst (
		.mclk(mclk), .reset_n(reset_n), .link(link_if.dev),
		.rail_reached(rail_reached), .rail_below60(rail_below60),
		.positive_output(pos_on), .negative_output(neg_on),
		.positive_code(pos_code), .negative_code(neg_code), .mode_code(mode),
		.overcurrent_guard(guard), .short_circuit_guard(short_trip),
		.wr_stb(wr_stb), .wr_index(wr_index), .wr_data(wr_data));
	// Second target faces the bench; its rails are of no interest here
	drbi_target #(.OCP_WIN_CYC(OCP_WIN), .SCP_CYC(SHORT_CIRCUIT_GUARD)) drbi_target_inst2 (
		.mclk(mclk), .reset_n(reset_n), .link(bad_if.dev),
		.rail_reached(rail_reached), .rail_below60(rail_below60),
		.positive_output(),
		.negative_output(), .positive_code(t2_pos), .negative_code(t2_neg),
		.mode_code(), .overcurrent_guard(), .short_circuit_guard(),
		.wr_stb(), .wr_index(), .wr_data());
	drbi_chk #(.HOLD_CYC(10), .QTR_CYC(QTR)) drbi_chk_inst (.mclk(mclk),
		.reset_n(reset_n), .scl(link_if.scl), .sda(link_if.sda),
		.sda_host_oe(link_if.sda_host_oe), .sda_dev_oe(link_if.sda_dev_oe),
		.first_enable_pin(link_if.first_enable_pin),
		.second_enable_pin(link_if.second_enable_pin));

	// Free-running system clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Line levels seen at each link clock rise, stop included
	always @(posedge link_if.scl)
		wire_bits <= {wire_bits[26:0], link_if.sda};

	// Store strobes of the joined target, one per data byte
	always @(posedge mclk)
		if (wr_stb === 1'b1)
			stb_count <= stb_count + 1;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// A bound ran out: count it and close the run
	task automatic expire(input string what);
		check(what, 32'h0, 32'h1);
		print_verdict();
	endtask : expire

	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			expire("apb ready");
		@(posedge mclk);
	endtask : apb

	// Start a one-byte write frame and poll until the engine is idle
	task automatic xfer(input logic [7:0] idx, input logic [7:0] d);
		int n;
		apb(1'b1, `DRBI_REG_XFER, {16'h0, idx, d});
		n = 0;
		do begin
			apb(1'b0, `DRBI_REG_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 400);
		if (n >= 400)
			expire("busy");
	endtask : xfer

	task automatic wait_rail(input logic neg, input logic v);
		int n;
		n = 0;
		while ((neg ? neg_on : pos_on) !== v && n < 400) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 400)
			expire("rail level");
	endtask : wait_rail

	// Hand-driven frame on the second link; na[j] is the ninth bit of byte j
	task automatic bb_frame(input logic [31:0] b, input int cnt,
		output logic [3:0] na);
		na = 4'h0;
		bad_if.sda_host_oe <= 1'b1;
		repeat (QTR) @(posedge mclk);
		bad_if.scl <= 1'b0;
		for (int j = 0; j < cnt; j++) begin
			for (int k = 8; k >= 0; k--) begin
				repeat (QTR) @(posedge mclk);
				bad_if.sda_host_oe <= (k > 0) ? !b[23 - 8 * j + k] : 1'b0;
				repeat (QTR) @(posedge mclk);
				bad_if.scl <= 1'b1;
				repeat (2 * QTR) @(posedge mclk);
				na[j] = bad_if.sda;
				bad_if.scl <= 1'b0;
			end
		end
		repeat (QTR) @(posedge mclk);
		bad_if.sda_host_oe <= 1'b1;
		repeat (QTR) @(posedge mclk);
		bad_if.scl <= 1'b1;
		repeat (QTR) @(posedge mclk);
		bad_if.sda_host_oe <= 1'b0;
		repeat (4 * QTR) @(posedge mclk);
	endtask : bb_frame

	// Main sequence
	initial begin
		rows = '{'{8'h00, 8'h15, 5'h15, 5'h0a, 8'h03},
			'{8'h01, 8'h07, 5'h15, 5'h07, 8'h03},
			'{8'h03, 8'h07, 5'h15, 5'h07, 8'h07},
			'{8'h02, 8'h1f, 5'h15, 5'h07, 8'h07},
			'{8'h04, 8'h1e, 5'h15, 5'h07, 8'h07},
			'{8'h00, 8'h0a, 5'h0a, 5'h07, 8'h07}};
		{reset_n, psel, penable, pwrite, paddr, pwdata} = 44'h0;
		{rail_reached, rail_below60} = 4'h0;
		{bad_if.scl, bad_if.sda_host_o, bad_if.sda_host_oe} = 3'h4;
		{bad_if.first_enable_pin, bad_if.second_enable_pin} = 2'h2;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check("idle", {link_if.scl, link_if.sda}, 2'h3);
		check("codes", {pos_code, neg_code, mode},
			{`DRBI_CODE_RST, `DRBI_CODE_RST, `DRBI_MODE_RST});
		check("rails", {pos_on, neg_on, short_trip, guard}, 5'h00);
		// Rail reached inside the window: limit relaxes
		rail_reached <= 2'h1;
		apb(1'b1, `DRBI_REG_CTRL, 32'h1);
		wait_rail(1'b0, 1'b1);
		apb(1'b0, `DRBI_REG_STAT, 32'h0);
		check("early stat", rd[3:2], 2'h0);
		check("neg off", neg_on, 1'b0);
		repeat (OCP_WIN + 8) @(posedge mclk);
		check("limit free", guard, LIM_FREE);
		apb(1'b1, `DRBI_REG_CTRL, 32'h0);
		wait_rail(1'b0, 1'b0);
		// Late ramp: strict, then weak until the rail recovers
		rail_reached <= 2'h0;
		apb(1'b1, `DRBI_REG_CTRL, 32'h1);
		wait_rail(1'b0, 1'b1);
		repeat (2) @(posedge mclk);
		check("limit strict", guard, LIM_STRICT);
		repeat (OCP_WIN + 8) @(posedge mclk);
		check("limit weak", guard, LIM_WEAK);
		rail_reached <= 2'h3;
		repeat (6) @(posedge mclk);
		check("limit back", guard, LIM_FREE);
		apb(1'b1, `DRBI_REG_CTRL, 32'h3);
		wait_rail(1'b1, 1'b1);
		repeat (70) @(posedge mclk);
		apb(1'b0, `DRBI_REG_STAT, 32'h0);
		check("late stat", rd[3:2], 2'h3);
		for (int i = 0; i < 6; i++) begin
			xfer(rows[i].idx, rows[i].data);
			check("frame", wire_bits, {WR_ADDR, 1'b0, rows[i].idx, 1'b0,
				rows[i].data, 2'h0});
			check("regs", {pos_code, neg_code, mode},
				{rows[i].pos, rows[i].neg, rows[i].mode});
		end
		check("last write", {wr_index, wr_data}, 16'h000a);
		check("strobes", stb_count, 32'h6);
		check("nack", rd[1], 1'b0);
		apb(1'b0, 8'h0c, 32'h0);
		check("unmapped", err, 1'b1);
		// A dip shorter than the count recovers; a full count latches
		rail_below60 <= 2'h1;
		repeat (SHORT_CIRCUIT_GUARD - 10) @(posedge mclk);
		rail_below60 <= 2'h0;
		repeat (4) @(posedge mclk);
		check("no trip", short_trip, 1'b0);
		rail_below60 <= 2'h2;
		repeat (SHORT_CIRCUIT_GUARD + 10) @(posedge mclk);
		rail_below60 <= 2'h0;
		repeat (20) @(posedge mclk);
		check("trip", {short_trip, pos_on, neg_on}, 3'h4);
		// Shutdown: level code 0x0a went out last, now the enables drop
		apb(1'b1, `DRBI_REG_CTRL, 32'h0);
		repeat (20) @(posedge mclk);
		check("en off", {link_if.first_enable_pin,
			link_if.second_enable_pin}, 2'h0);
		reset_n <= 1'b0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check("por", {short_trip, pos_code}, 6'h0a);
		// Second link: read direction, foreign address, two data bytes
		bb_frame({WR_ADDR | 8'h01, 24'h001500}, 3, nacks);
		check("read dir", nacks, 4'h7);
		bb_frame(32'h4000_1500, 3, nacks);
		check("foreign", {nacks, t2_pos}, {4'h7, 5'h0a});
		bb_frame({WR_ADDR, 24'h001213}, 4, nacks);
		check("burst", {nacks, t2_pos, t2_neg}, 14'h0253);
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
